// ---- hdl/dbs_event_select.sv ----
// Purpose: Priority selection among the sequencer's advancing events.
// Assumes: Event inputs are already qualified by their enables.
// Notes:   Purely combinational; the caller registers the outcome.
`timescale 1ns/1ps
`default_nettype none
module dbs_event_select
  import dbs_pkg::*;
(
  // Qualified events.
  input  wire logic              force_in,
  input  wire logic              ext_in,
  input  wire logic              hit3_in,
  input  wire logic              hit1_in,
  input  wire logic              hit0_in,
  // State control word of the current state.
  input  wire logic [CTRL_W-1:0] ctrl_in,
  // Selected outcome.
  output logic                   hit_out,
  output dbs_state_t             next_out,
  output dbs_cause_t             cause_out
);

  // Selector fields of the current state control word.
  logic [STATE_W-1:0] sel_ext;
  logic [STATE_W-1:0] sel_m3;
  logic [STATE_W-1:0] sel_m1;
  logic [STATE_W-1:0] sel_m0;
  assign sel_ext = ctrl_in[CTRL_EXT_LO +: STATE_W];
  assign sel_m3  = ctrl_in[CTRL_M3_LO  +: STATE_W];
  assign sel_m1  = ctrl_in[CTRL_M1_LO  +: STATE_W];
  assign sel_m0  = ctrl_in[CTRL_M0_LO  +: STATE_W];

  // Fixed priority chain: force first, then external, then hits 3, 1, 0.
  assign hit_out = force_in | ext_in | hit3_in | hit1_in | hit0_in;

  // The force event always targets the final state, ignoring the control word.
  assign next_out = force_in ? DBS_FINAL :
                    ext_in   ? dbs_state_t'(sel_ext) :
                    hit3_in  ? dbs_state_t'(sel_m3) :
                    hit1_in  ? dbs_state_t'(sel_m1) :
                    hit0_in  ? dbs_state_t'(sel_m0) :
                               DBS_STATE0;

  // Cause follows the same chain; status takes it only when the winning event moves the sequencer.
  assign cause_out = force_in ? DBS_CAUSE_FORCE :
                     ext_in   ? DBS_CAUSE_EXT :
                     hit3_in  ? DBS_CAUSE_HIT3 :
                     hit1_in  ? DBS_CAUSE_HIT1 :
                     hit0_in  ? DBS_CAUSE_HIT0 :
                                DBS_CAUSE_NONE;

endmodule
`default_nettype wire

// ---- hdl/dbs_pkg.sv ----
// Purpose: Shared constants and types for the debug breakpoint sequencer.
// Assumes: One clock domain; all control inputs are synchronous to it.
// Notes:   State codes are the values shown on the state indication field.
package dbs_pkg;

  // Width of the state indication field and of every next-state selector.
  localparam int unsigned STATE_W = 3;

  // Sequencer states; the binary index of states 0 to 3 is shown directly.
  typedef enum logic [2:0] {
    DBS_STATE0 = 3'h0,
    DBS_STATE1 = 3'h1,
    DBS_STATE2 = 3'h2,
    DBS_STATE3 = 3'h3,
    DBS_FINAL  = 3'h4
  } dbs_state_t;

  // Reset values.
  localparam dbs_state_t STATE_RST = DBS_STATE0;
  localparam logic       ARMED_RST = 1'b0;
  localparam logic       BREAK_RST = 1'b0;

  // External event enable value that lets the external event steer the sequencer.
  localparam logic [1:0] EXT_EVENT_ADVANCE = 2'h2;

  // Layout of one state control word: one next-state selector per event source except the force event.
  localparam int unsigned CTRL_W      = 12;
  localparam int unsigned CTRL_EXT_LO = 0;
  localparam int unsigned CTRL_M3_LO  = 3;
  localparam int unsigned CTRL_M1_LO  = 6;
  localparam int unsigned CTRL_M0_LO  = 9;

  // Cause codes reported for the most recent transition.
  typedef enum logic [2:0] {
    DBS_CAUSE_NONE   = 3'h0,
    DBS_CAUSE_FORCE  = 3'h1,
    DBS_CAUSE_EXT    = 3'h2,
    DBS_CAUSE_HIT3   = 3'h3,
    DBS_CAUSE_HIT1   = 3'h4,
    DBS_CAUSE_HIT0   = 3'h5,
    DBS_CAUSE_ARM    = 3'h6,
    DBS_CAUSE_DISARM = 3'h7
  } dbs_cause_t;

endpackage

// ---- hdl/dbs_sequencer.sv ----
// Purpose: State sequencer that turns a chain of debug events into a breakpoint request.
// Assumes: All inputs are synchronous to CLK_IN; the arm write is a one-cycle strobe.
// Notes:   Control and status bits are plain ports; there is no register bus.
`timescale 1ns/1ps
`default_nettype none

module dbs_sequencer
  import dbs_pkg::*;
(
  // Clock and reset.
  input  wire logic               CLK_IN,
  input  wire logic               RSTN_IN,
  // Arm control write strobe and its data bit.
  input  wire logic               ARM_WRITE_IN,
  input  wire logic               ARM_DATA_IN,
  // Breakpoint enable.
  input  wire logic               BREAK_ENABLE_IN,
  // External event and its enable field.
  input  wire logic               EXTERNAL_DEBUG_EVENT_IN,
  input  wire logic [1:0]         EXTERNAL_EVENT_ENABLE_FIELD_IN,
  // Immediate force event and comparator hits.
  input  wire logic               IMMEDIATE_FORCE_EVENT_IN,
  input  wire logic               COMPARATOR_HIT_3_IN,
  input  wire logic               COMPARATOR_HIT_1_IN,
  input  wire logic               COMPARATOR_HIT_0_IN,
  // State control words for states 1, 2 and 3.
  input  wire logic [CTRL_W-1:0]  STATE1_CONTROL_IN,
  input  wire logic [CTRL_W-1:0]  STATE2_CONTROL_IN,
  input  wire logic [CTRL_W-1:0]  STATE3_CONTROL_IN,
  // Status.
  output logic [STATE_W-1:0]      SEQUENCER_STATE_FLAGS_OUT,
  output logic                    ARMED_OUT,
  output logic [2:0]              LAST_CAUSE_OUT,
  output logic                    STATE_CHANGE_OUT,
  // Breakpoint request towards the processor core.
  output logic                    BREAK_REQUEST_OUT
);

  // Picks the control word that belongs to the given state.
  function automatic logic [CTRL_W-1:0] pick_ctrl(
    input dbs_state_t        st,
    input logic [CTRL_W-1:0] c1,
    input logic [CTRL_W-1:0] c2,
    input logic [CTRL_W-1:0] c3
  );
    logic [CTRL_W-1:0] r;
    r = '0;
    if (st == DBS_STATE1) begin
      r = c1;
    end else if (st == DBS_STATE2) begin
      r = c2;
    end else if (st == DBS_STATE3) begin
      r = c3;
    end
    return r;
  endfunction

  // True for the three armed intermediate states.
  function automatic logic is_active(input dbs_state_t st);
    return (st == DBS_STATE1) || (st == DBS_STATE2) || (st == DBS_STATE3);
  endfunction

  // A selector is usable only if it names a defined state.
  function automatic logic is_valid_target(input dbs_state_t st);
    return is_active(st) || (st == DBS_STATE0) || (st == DBS_FINAL);
  endfunction

  // State and status registers.
  dbs_state_t state_reg;
  dbs_state_t state_next;
  logic       armed_reg;
  logic       armed_next;
  logic       break_reg;
  logic       break_next;
  dbs_cause_t cause_reg;
  dbs_cause_t cause_next;
  logic       change_reg;
  logic       change_next;

  // Decoded conditions.
  logic              in_final;
  logic              in_active;
  logic              arm_set;
  logic              arm_clear;
  logic              ext_qual;
  logic [CTRL_W-1:0] cur_ctrl;
  logic              sel_hit;
  dbs_state_t        sel_next;
  dbs_cause_t        sel_cause;
  logic              ev_move;
  logic              ev_to_idle;

  // Current state classification.
  assign in_final  = (state_reg == DBS_FINAL);
  assign in_active = is_active(state_reg);

  // Arm writes; a one only acts while disarmed, a zero only while armed.
  assign arm_set   = ARM_WRITE_IN & ARM_DATA_IN & ~armed_reg & (state_reg == DBS_STATE0);
  assign arm_clear = ARM_WRITE_IN & ~ARM_DATA_IN & armed_reg;

  // The external event counts only under the advancing enable value.
  assign ext_qual = EXTERNAL_DEBUG_EVENT_IN &
                    (EXTERNAL_EVENT_ENABLE_FIELD_IN == EXT_EVENT_ADVANCE);

  // Control word of the state we are in; unused outside states 1 to 3.
  assign cur_ctrl = pick_ctrl(state_reg, STATE1_CONTROL_IN, STATE2_CONTROL_IN,
                              STATE3_CONTROL_IN);

  // Priority selection among the advancing events.
  dbs_event_select u_select (
    .force_in  (IMMEDIATE_FORCE_EVENT_IN),
    .ext_in    (ext_qual),
    .hit3_in   (COMPARATOR_HIT_3_IN),
    .hit1_in   (COMPARATOR_HIT_1_IN),
    .hit0_in   (COMPARATOR_HIT_0_IN),
    .ctrl_in   (cur_ctrl),
    .hit_out   (sel_hit),
    .next_out  (sel_next),
    .cause_out (sel_cause)
  );

  // Events move the sequencer only from states 1 to 3, and only to a defined
  // state other than the current one. Events are not examined in the final
  // state, so nothing but the return to State0 can follow it.
  assign ev_move    = in_active & sel_hit & is_valid_target(sel_next) &
                      (sel_next != state_reg);
  assign ev_to_idle = ev_move & (sel_next == DBS_STATE0);

  // Next state. Software disarm has the last word over any coincident event,
  // so a user can always abandon a sequence without a breakpoint.
  assign state_next = arm_clear  ? DBS_STATE0 :
                      in_final   ? DBS_STATE0 :
                      arm_set    ? DBS_STATE1 :
                      ev_move    ? sel_next :
                                   state_reg;

  // Armed condition follows the state: cleared on every return to State0.
  assign armed_next = arm_clear  ? 1'b0 :
                      in_final   ? 1'b0 :
                      ev_to_idle ? 1'b0 :
                      arm_set    ? 1'b1 :
                                   armed_reg;

  // Breakpoint request for event-driven arrivals at State0 only; the final
  // state return counts as event driven because an event put us there.
  assign break_next = BREAK_ENABLE_IN & ~arm_clear &
                      (in_final | ev_to_idle);

  // Cause of the transition now being taken, if any.
  assign cause_next = arm_clear ? DBS_CAUSE_DISARM :
                      in_final  ? cause_reg :
                      arm_set   ? DBS_CAUSE_ARM :
                      ev_move   ? sel_cause :
                                  cause_reg;

  // One-cycle strobe marking that the state indication has just changed.
  assign change_next = (state_next != state_reg);

  // Sequencer state; its code drives the state indication field directly.
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Armed condition and breakpoint request.
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      armed_reg <= ARMED_RST;
      break_reg <= BREAK_RST;
    end else begin
      armed_reg <= armed_next;
      break_reg <= break_next;
    end
  end

  // Status of the most recent transition.
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cause_reg  <= DBS_CAUSE_NONE;
      change_reg <= 1'b0;
    end else begin
      cause_reg  <= cause_next;
      change_reg <= change_next;
    end
  end

  // Outputs straight from the registers. The final state code is seen for a
  // single cycle only, because the sequencer leaves it on the next edge.
  assign SEQUENCER_STATE_FLAGS_OUT = state_reg;
  assign ARMED_OUT                 = armed_reg;
  assign LAST_CAUSE_OUT            = cause_reg;
  assign STATE_CHANGE_OUT          = change_reg;
  assign BREAK_REQUEST_OUT         = break_reg;

endmodule
`default_nettype wire

// ---- tb/dbs_core_model.sv ----
// Purpose: Processor core stand-in that receives breakpoint requests.
// Assumes: A request is a one-cycle pulse sampled on the rising edge.
// Notes:   Never reset, so the tally survives a mid-run reset of the block.
`timescale 1ns/1ps
`default_nettype none
module dbs_core_model (
  // Clock and request from the sequencer.
  input  wire logic      clk_in,
  input  wire logic      break_request_in,
  // Number of requests taken so far.
  output var int unsigned breaks_out
);
  // Each high sample is one request; the core never refuses one.
  initial breaks_out = 0;
  always @(posedge clk_in) begin
    if (break_request_in === 1'b1) begin
      breaks_out <= breaks_out + 1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/dbs_seq_properties.sv ----
// Purpose: Port-level assertions for the debug breakpoint sequencer.
// Assumes: One clock; reset is asynchronous and active low.
// Notes:   Armed sequencer states are 1 to 4; 4 is the final state.
`timescale 1ns/1ps
`default_nettype none
module dbs_seq_properties
  import dbs_pkg::*;
(
  // Clock and reset.
  input wire logic              CLK_IN,
  input wire logic              RSTN_IN,
  // Controls and events.
  input wire logic              ARM_WRITE_IN,
  input wire logic              ARM_DATA_IN,
  input wire logic              BREAK_ENABLE_IN,
  input wire logic              EXTERNAL_DEBUG_EVENT_IN,
  input wire logic [1:0]        EXTERNAL_EVENT_ENABLE_FIELD_IN,
  input wire logic              IMMEDIATE_FORCE_EVENT_IN,
  input wire logic              COMPARATOR_HIT_3_IN,
  input wire logic              COMPARATOR_HIT_1_IN,
  input wire logic              COMPARATOR_HIT_0_IN,
  input wire logic [CTRL_W-1:0] STATE1_CONTROL_IN,
  input wire logic [CTRL_W-1:0] STATE2_CONTROL_IN,
  input wire logic [CTRL_W-1:0] STATE3_CONTROL_IN,
  // Status and request.
  input wire logic [STATE_W-1:0] SEQUENCER_STATE_FLAGS_OUT,
  input wire logic              ARMED_OUT,
  input wire logic [2:0]        LAST_CAUSE_OUT,
  input wire logic              STATE_CHANGE_OUT,
  input wire logic              BREAK_REQUEST_OUT
);
  // Shorthands; a disarm write outranks every event, so it is excluded from live.
  wire logic [2:0] st   = SEQUENCER_STATE_FLAGS_OUT;
  wire logic       kill = ARM_WRITE_IN && !ARM_DATA_IN;
  wire logic       live = ARMED_OUT && st != 3'h0 && st != 3'h4 && !kill;
  wire logic [2:0] s3   = STATE1_CONTROL_IN[5:3];
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // Final state is left on the next edge, towards a disarmed State0.
  sequence s_final_back;
    st == 3'h4 ##1 (st == 3'h0 && !ARMED_OUT);
  endsequence
  sequence s_hit3_only;
    live && st == 3'h1 && COMPARATOR_HIT_3_IN && !IMMEDIATE_FORCE_EVENT_IN
      && !EXTERNAL_DEBUG_EVENT_IN;
  endsequence
  a_force_final: assert property (live && IMMEDIATE_FORCE_EVENT_IN |=> st == 3'h4)
    else $error("force event did not reach final state");
  a_ext_gated: assert property (live && EXTERNAL_DEBUG_EVENT_IN
    && EXTERNAL_EVENT_ENABLE_FIELD_IN != EXT_EVENT_ADVANCE && !IMMEDIATE_FORCE_EVENT_IN
    && !COMPARATOR_HIT_3_IN && !COMPARATOR_HIT_1_IN && !COMPARATOR_HIT_0_IN |=> $stable(st))
    else $error("external event moved while not enabled");
  a_hit3_wins: assert property (s_hit3_only |=>
    st == (($past(s3) > 3'h4) ? 3'h1 : $past(s3)))
    else $error("hit 3 did not take its selected state");
  a_arm_enter: assert property (ARM_WRITE_IN && ARM_DATA_IN && !ARMED_OUT && st == 3'h0
    |=> st == 3'h1 && ARMED_OUT) else $error("arm write did not enter State1");
  a_final_back: assert property (st == 3'h4 |-> s_final_back)
    else $error("final state not left towards disarmed State0");
  a_change_flag: assert property (STATE_CHANGE_OUT == (st != $past(st)))
    else $error("state change pulse disagrees with state field");
  a_final_break: assert property (st == 3'h4 && !kill |=>
    BREAK_REQUEST_OUT == $past(BREAK_ENABLE_IN))
    else $error("final return request wrong");
  a_break_cause: assert property (BREAK_REQUEST_OUT |-> st == 3'h0 && $past(st) != 3'h0
    && $past(BREAK_ENABLE_IN)) else $error("request without enabled move to State0");
  a_disarm_quiet: assert property (kill && ARMED_OUT |=> st == 3'h0 && !ARMED_OUT
    && !BREAK_REQUEST_OUT) else $error("disarm write misbehaved");
  a_reset_clear: assert property ($rose(RSTN_IN) |-> st == 3'h0 && !ARMED_OUT
    && !BREAK_REQUEST_OUT) else $error("reset state wrong");
endmodule
bind dbs_sequencer dbs_seq_properties i_dbs_seq_properties (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Random stimulus with a queued reference for the breakpoint sequencer.
// Assumes: Outputs answer one rising edge after the inputs that cause them.
// Notes:   The reference keeps its own state; armed is modelled as state not zero.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dbs_pkg::*;
  logic CLK_IN = 1'b0, RSTN_IN = 1'b0, ARM_WRITE_IN = 1'b0, ARM_DATA_IN = 1'b0;
  logic BREAK_ENABLE_IN = 1'b0, EXTERNAL_DEBUG_EVENT_IN = 1'b0, IMMEDIATE_FORCE_EVENT_IN = 1'b0;
  logic COMPARATOR_HIT_3_IN = 1'b0, COMPARATOR_HIT_1_IN = 1'b0, COMPARATOR_HIT_0_IN = 1'b0;
  logic [1:0] EXTERNAL_EVENT_ENABLE_FIELD_IN = 2'h0;
  logic [CTRL_W-1:0] STATE1_CONTROL_IN = '0, STATE2_CONTROL_IN = '0, STATE3_CONTROL_IN = '0;
  logic [2:0] SEQUENCER_STATE_FLAGS_OUT, LAST_CAUSE_OUT, m_st = 3'h0, m_cause = 3'h0;
  logic ARMED_OUT, STATE_CHANGE_OUT, BREAK_REQUEST_OUT;
  int unsigned breaks_seen;
  int err_total = 0, checks_done = 0, seed = 92, exp_breaks = 0;
  logic [7:0] notes[$];
  wire logic [7:0] seen = {BREAK_REQUEST_OUT, ARMED_OUT, LAST_CAUSE_OUT, SEQUENCER_STATE_FLAGS_OUT};
  dbs_sequencer i_dbs_sequencer (.*);
  dbs_core_model i_dbs_core_model (.clk_in(CLK_IN), .break_request_in(BREAK_REQUEST_OUT),
    .breaks_out(breaks_seen));
  // Free-running 250 MHz clock.
  initial begin
    forever #2 CLK_IN = ~CLK_IN;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  function automatic logic r(input int m);
    return ($random(seed) & m) == 0;
  endfunction
  // Each state change pops the oldest note; a lone request pulse is always wrong.
  always @(negedge CLK_IN) begin
    if (RSTN_IN && STATE_CHANGE_OUT !== 1'b0) begin
      check(seen, (notes.size() > 0) ? notes.pop_front() : 8'hFF);
    end else if (RSTN_IN && BREAK_REQUEST_OUT !== 1'b0) begin
      check({7'h00, BREAK_REQUEST_OUT}, 8'h00);
    end
  end
  // Drive one cycle at the falling edge and predict the next edge's outcome.
  task automatic step(input bit rnd);
    logic [2:0] nx, ca, sel;
    logic [CTRL_W-1:0] c;
    logic bk;
    @(negedge CLK_IN);
    ARM_WRITE_IN = r(7) && rnd;
    ARM_DATA_IN = r(1);
    BREAK_ENABLE_IN = r(1);
    IMMEDIATE_FORCE_EVENT_IN = r(15) && rnd;
    EXTERNAL_DEBUG_EVENT_IN = r(3) && rnd;
    COMPARATOR_HIT_3_IN = r(3) && rnd;
    COMPARATOR_HIT_1_IN = r(3) && rnd;
    COMPARATOR_HIT_0_IN = r(3) && rnd;
    EXTERNAL_EVENT_ENABLE_FIELD_IN = 2'($random(seed));
    {STATE1_CONTROL_IN, STATE2_CONTROL_IN} = 24'($random(seed));
    STATE3_CONTROL_IN = 12'($random(seed));
    {nx, ca, bk, sel} = {m_st, m_cause, 1'b0, 3'h7};
    c = (m_st == 3'h1) ? STATE1_CONTROL_IN : (m_st == 3'h2) ? STATE2_CONTROL_IN : STATE3_CONTROL_IN;
    if (ARM_WRITE_IN && !ARM_DATA_IN && m_st != 3'h0) begin
      {nx, ca} = {3'h0, DBS_CAUSE_DISARM};
    end else if (m_st == 3'h4) begin
      {nx, bk} = {3'h0, BREAK_ENABLE_IN};
    end else if (ARM_WRITE_IN && ARM_DATA_IN && m_st == 3'h0) begin
      {nx, ca} = {3'h1, DBS_CAUSE_ARM};
    end else if (m_st != 3'h0) begin
      if (IMMEDIATE_FORCE_EVENT_IN) {sel, ca} = {3'h4, DBS_CAUSE_FORCE};
      else if (EXTERNAL_DEBUG_EVENT_IN && EXTERNAL_EVENT_ENABLE_FIELD_IN == EXT_EVENT_ADVANCE)
        {sel, ca} = {c[2:0], DBS_CAUSE_EXT};
      else if (COMPARATOR_HIT_3_IN) {sel, ca} = {c[5:3], DBS_CAUSE_HIT3};
      else if (COMPARATOR_HIT_1_IN) {sel, ca} = {c[8:6], DBS_CAUSE_HIT1};
      else if (COMPARATOR_HIT_0_IN) {sel, ca} = {c[11:9], DBS_CAUSE_HIT0};
      if (sel <= 3'h4 && sel != m_st) begin
        {nx, bk} = {sel, sel == 3'h0 && BREAK_ENABLE_IN};
      end else begin
        ca = m_cause;
      end
    end
    if (nx != m_st) begin
      notes.push_back({bk, nx != 3'h0, ca, nx});
    end
    exp_breaks += int'(bk);
    {m_st, m_cause} = {nx, ca};
  endtask
  // Reset is applied away from both edges so the monitor never races it.
  // Two idle edges first, so a request pulse from the last step reaches the core model.
  task automatic do_reset();
    repeat (2) @(negedge CLK_IN);
    #1 RSTN_IN = 1'b0;
    notes.delete();
    {m_st, m_cause} = 6'h00;
    repeat (3) @(negedge CLK_IN);
    RSTN_IN = 1'b1;
    check(seen, 8'h00);
  endtask
  initial begin
    do_reset();
    for (int i = 0; i < 3000; i++) begin
      step(1'b1);
      if (i == 1500) begin
        step(1'b0);
        do_reset();
      end
    end
    step(1'b0);
    step(1'b0);
    @(negedge CLK_IN);
    #1 check(8'(notes.size()), 8'h00);
    check(8'(breaks_seen), 8'(exp_breaks));
    tally_and_finish();
  end
  // Watchdog sized well above the 3000-cycle run.
  initial begin
    #40000;
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
